// ---- design/csrd_pkg.sv ----
// Shared constants for the chip-select range decoder
package csrd_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_UPPER   = 8'h00;
    localparam logic [7:0] OFF_LOWER   = 8'h04;
    localparam logic [7:0] OFF_MIDBASE = 8'h08;
    localparam logic [7:0] OFF_PERBASE = 8'h0c;
    localparam logic [7:0] OFF_ALT     = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WAIT_LSB     = 0;
    localparam int RDY_IGN_BIT  = 2;
    localparam int REGION_LSB   = 6;
    localparam int MID_BASE_LSB = 9;
    localparam int PER_BASE_LSB = 6;
    localparam int BLK_LSB      = 8;
    localparam int PIN_SEL_BIT  = 7;
    localparam int CYC_SEL_BIT  = 6;

    // ------------------------------------------------------------
    // Reset values and writable masks (reserved bits read zero)
    // ------------------------------------------------------------
    localparam logic [15:0] UPPER_RST   = 16'h3fc3;
    localparam logic [15:0] LOWER_RST   = 16'h0003;
    localparam logic [15:0] MIDBASE_RST = 16'h0003;
    localparam logic [15:0] PERBASE_RST = 16'h0003;
    localparam logic [15:0] ALT_RST     = 16'h0003;
    localparam logic [15:0] REGION_MASK = 16'h3fc7;
    localparam logic [15:0] MIDB_MASK   = 16'hfe07;
    localparam logic [15:0] PERB_MASK   = 16'hffc7;
    localparam logic [15:0] ALT_MASK    = 16'h7fc7;

    // ------------------------------------------------------------
    // Decode geometry
    // ------------------------------------------------------------
    localparam int          PER_COUNT  = 7;
    localparam int          MID_COUNT  = 4;
    localparam logic [19:0] PER_SPAN   = 20'h00380;
    localparam logic [4:0]  MID_Q_BASE = 5'h0b;

    // ------------------------------------------------------------
    // Bus cycle sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSRD_IDLE = 3'b001,
        CSRD_WAIT = 3'b010,
        CSRD_DONE = 3'b100
    } csrd_state_t;

endpackage

// ---- design/csrd_mid_decode.sv ----
// Mid-range block match and quarter index
`timescale 1ns/10ps
module csrd_mid_decode
    import csrd_pkg::*;
(
    input  wire logic [19:0] addr,
    input  wire logic [6:0]  base,
    input  wire logic [6:0]  blk,
    output logic             hit,
    output logic [1:0]       quarter
);

    function automatic logic [2:0] top_bit(input logic [6:0] f);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (f[i]) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction

    logic [2:0]  k;
    logic [7:0]  span;
    logic [7:0]  diff;
    logic [19:0] offs;
    logic [19:0] shifted;

    always_comb begin
        k       = top_bit(blk);
        span    = 8'h01 << k;
        diff    = {1'b0, addr[19:13]} - {1'b0, base};
        hit     = (blk != 7'h00) && (addr[19:13] >= base) && (diff < span);
        offs    = addr - {base, 13'h0};
        shifted = offs >> (MID_Q_BASE + {2'h0, k});
        quarter = shifted[1:0];
    end

endmodule

// ---- design/csrd_per_decode.sv ----
// Peripheral select window match and select index
`timescale 1ns/10ps
module csrd_per_decode
    import csrd_pkg::*;
(
    input  wire logic [19:0] addr,
    input  wire logic [9:0]  base,
    output logic             hit,
    output logic [2:0]       idx
);

    logic [20:0] offs;

    always_comb begin
        offs = {1'b0, addr} - {1'b0, base, 10'h000};
        hit  = !offs[20] && (offs[19:0] < PER_SPAN);
        idx  = offs[9:7];
    end

endmodule

// ---- design/csrd_top.sv ----
// Chip-select range decoder: APB registers, address decode, wait and ready sequencing
`timescale 1ns/10ps
module csrd_top
    import csrd_pkg::*;
#(
    parameter int TSTATE_DIV = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cyc_start,
    input  wire logic        cyc_is_mem,
    input  wire logic [19:0] cyc_addr,
    input  wire logic        bus_ready,
    output logic             upper_region_select_n,
    output logic             lower_region_select_n,
    output logic [3:0]       mid_range_select_n,
    output logic [6:0]       peripheral_select_n,
    output logic             cycle_done
);

    // ------------------------------------------------------------
    // Register address decode
    // ------------------------------------------------------------
    function automatic logic [5:0] reg_hit(input logic [7:0] a);
        logic [5:0] h;
        h    = 6'h00;
        h[0] = (a == OFF_UPPER);
        h[1] = (a == OFF_LOWER);
        h[2] = (a == OFF_MIDBASE);
        h[3] = (a == OFF_PERBASE);
        h[4] = (a == OFF_ALT);
        h[5] = (a == OFF_STATUS);
        return h;
    endfunction

    logic [15:0] upper_region_control_q;
    logic [15:0] lower_region_control_q;
    logic [15:0] mid_range_base_control_q;
    logic [15:0] peripheral_select_base_q;
    logic [15:0] midrange_peripheral_alt_control_q;
    logic [31:0] prdata_q;
    logic [5:0]  acc_hit;
    logic [5:0]  setup_hit;
    logic        apb_acc;
    logic        apb_wr;

    assign apb_acc   = psel & penable;
    assign apb_wr    = apb_acc & pwrite;
    assign acc_hit   = reg_hit(paddr) & {6{apb_acc}};
    assign setup_hit = reg_hit(paddr);
    assign pready    = 1'b1;
    assign pslverr   = apb_acc & ~(|setup_hit);
    assign prdata    = prdata_q;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_region_control_q <= UPPER_RST;
        end else if (apb_wr && acc_hit[0]) begin
            upper_region_control_q <= pwdata[15:0] & REGION_MASK;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_region_control_q <= LOWER_RST;
        end else if (apb_wr && acc_hit[1]) begin
            lower_region_control_q <= pwdata[15:0] & REGION_MASK;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_range_base_control_q <= MIDBASE_RST;
        end else if (apb_wr && acc_hit[2]) begin
            mid_range_base_control_q <= pwdata[15:0] & MIDB_MASK;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_select_base_q <= PERBASE_RST;
        end else if (apb_wr && acc_hit[3]) begin
            peripheral_select_base_q <= pwdata[15:0] & PERB_MASK;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            midrange_peripheral_alt_control_q <= ALT_RST;
        end else if (apb_wr && acc_hit[4]) begin
            midrange_peripheral_alt_control_q <= pwdata[15:0] & ALT_MASK;
        end
    end

    // ------------------------------------------------------------
    // Select enables
    // ------------------------------------------------------------
    // Any access, read or write, to a control register arms its select; mid-range and peripheral selects also need the alt register; only reset disarms it.
    logic [4:0] touched_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            touched_q <= 5'h00;
        end else begin
            touched_q <= touched_q | acc_hit[4:0];
        end
    end

    logic en_upper;
    logic en_lower;
    logic en_mid;
    logic en_per;
    assign en_upper = touched_q[0];
    assign en_lower = touched_q[1];
    assign en_mid   = touched_q[2] & touched_q[4];
    assign en_per   = touched_q[3] & touched_q[4];

    // ------------------------------------------------------------
    // Bus ready synchroniser and T-state divider
    // ------------------------------------------------------------
    logic       ready_meta_q;
    logic       ready_sync_q;
    logic [7:0] tdiv_q;
    logic       tstate_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_meta_q <= 1'b0;
            ready_sync_q <= 1'b0;
        end else begin
            ready_meta_q <= bus_ready;
            ready_sync_q <= ready_meta_q;
        end
    end
    assign tstate_en = (tdiv_q == 8'(TSTATE_DIV - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdiv_q <= 8'h00;
        end else if (tstate_en) begin
            tdiv_q <= 8'h00;
        end else begin
            tdiv_q <= tdiv_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Address decode of the cycle being started
    // ------------------------------------------------------------
    logic       upper_hit;
    logic       lower_hit;
    logic       mid_raw;
    logic [1:0] mid_q;
    logic       per_raw;
    logic [2:0] per_idx;
    logic       per_type_ok;
    logic [3:0] mid_vec;
    logic [6:0] per_vec;

    // Region compares run in 1 Kbyte granules on address bits 17:10.
    assign upper_hit = en_upper && cyc_is_mem && (cyc_addr[19:18] == 2'b11)
        && (cyc_addr[17:10] >= upper_region_control_q[REGION_LSB +: 8]);
    assign lower_hit = en_lower && cyc_is_mem && (cyc_addr[19:18] == 2'b00)
        && (cyc_addr[17:10] <= lower_region_control_q[REGION_LSB +: 8]);

    csrd_mid_decode u_mid (
        .addr    (cyc_addr),
        .base    (mid_range_base_control_q[MID_BASE_LSB +: 7]),
        .blk     (midrange_peripheral_alt_control_q[BLK_LSB +: 7]),
        .hit     (mid_raw),
        .quarter (mid_q)
    );

    csrd_per_decode u_per (
        .addr (cyc_addr),
        .base (peripheral_select_base_q[PER_BASE_LSB +: 10]),
        .hit  (per_raw),
        .idx  (per_idx)
    );

    assign per_type_ok = midrange_peripheral_alt_control_q[CYC_SEL_BIT]
                       ? cyc_is_mem : ~cyc_is_mem;

    genvar gi;
    generate
        for (gi = 0; gi < MID_COUNT; gi++) begin : g_mid
            assign mid_vec[gi] = en_mid && cyc_is_mem && mid_raw
                              && (mid_q == 2'(gi));
        end
        for (gi = 0; gi < PER_COUNT; gi++) begin : g_per
            assign per_vec[gi] = en_per && per_type_ok && per_raw
                              && (per_idx == 3'(gi));
        end
    endgenerate

    // ------------------------------------------------------------
    // Wait and ready setting for the cycle
    // ------------------------------------------------------------
    // Overlaps resolve mid-range first, then peripheral selects 4 to 6, then the lower and upper regions, then peripheral selects 0 to 3.
    logic [2:0] timing;

    always_comb begin
        if (|mid_vec) begin
            timing = midrange_peripheral_alt_control_q[2:0];
        end else if (|per_vec[6:4]) begin
            timing = midrange_peripheral_alt_control_q[2:0];
        end else if ((|per_vec[3:0]) && lower_hit) begin
            timing = lower_region_control_q[2:0];
        end else if ((|per_vec[3:0]) && upper_hit) begin
            timing = upper_region_control_q[2:0];
        end else if (|per_vec[3:0]) begin
            timing = peripheral_select_base_q[2:0];
        end else if (lower_hit) begin
            timing = lower_region_control_q[2:0];
        end else if (upper_hit) begin
            timing = upper_region_control_q[2:0];
        end else begin
            timing = 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    csrd_state_t state_q;
    logic [1:0]  wait_cnt_q;
    logic        ign_rdy_q;
    logic        end_now;
    // A cycle that ignores ready ends after its waits and cannot be lengthened.
    assign end_now = tstate_en && (wait_cnt_q == 2'h0)
                  && (ign_rdy_q || ready_sync_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CSRD_IDLE;
        end else begin
            unique case (state_q)
                CSRD_IDLE: begin
                    if (cyc_start) begin
                        state_q <= CSRD_WAIT;
                    end
                end
                CSRD_WAIT: begin
                    if (end_now) begin
                        state_q <= CSRD_DONE;
                    end
                end
                CSRD_DONE: begin
                    state_q <= CSRD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_q <= 2'h0;
            ign_rdy_q  <= 1'b0;
        end else if (state_q == CSRD_IDLE && cyc_start) begin
            wait_cnt_q <= timing[WAIT_LSB +: 2];
            ign_rdy_q  <= timing[RDY_IGN_BIT];
        end else if (state_q == CSRD_WAIT && tstate_en && wait_cnt_q != 2'h0) begin
            wait_cnt_q <= wait_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_done <= 1'b0;
        end else begin
            cycle_done <= (state_q == CSRD_WAIT) && end_now;
        end
    end

    // ------------------------------------------------------------
    // Select outputs
    // ------------------------------------------------------------
    logic       start_take;
    logic       pin_sel;
    logic [1:0] addr_lat_q;
    assign start_take = (state_q == CSRD_IDLE) && cyc_start;
    assign pin_sel    = midrange_peripheral_alt_control_q[PIN_SEL_BIT];

    // Address latch for the shared pins holds between cycles like a latch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_lat_q <= 2'h0;
        end else if (start_take) begin
            addr_lat_q <= cyc_addr[2:1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_region_select_n <= 1'b1;
            lower_region_select_n <= 1'b1;
            mid_range_select_n    <= 4'hf;
            peripheral_select_n   <= 7'h7f;
        end else if (start_take) begin
            upper_region_select_n <= ~upper_hit;
            lower_region_select_n <= ~lower_hit;
            mid_range_select_n    <= ~mid_vec;
            peripheral_select_n   <= pin_sel ? ~per_vec
                                  : {cyc_addr[2:1], ~per_vec[4:0]};
        end else if (state_q == CSRD_DONE) begin
            upper_region_select_n <= 1'b1;
            lower_region_select_n <= 1'b1;
            mid_range_select_n    <= 4'hf;
            peripheral_select_n   <= pin_sel ? 7'h7f
                                  : {addr_lat_q, 5'h1f};
        end
    end

    // ------------------------------------------------------------
    // Read path, loaded in the setup phase so data stands in access
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            setup_hit[0]: rd_mux[15:0] = upper_region_control_q;
            setup_hit[1]: rd_mux[15:0] = lower_region_control_q;
            setup_hit[2]: rd_mux[15:0] = mid_range_base_control_q;
            setup_hit[3]: rd_mux[15:0] = peripheral_select_base_q;
            setup_hit[4]: rd_mux[15:0] = midrange_peripheral_alt_control_q;
            setup_hit[5]: rd_mux[6:0]  = {ready_sync_q, state_q != CSRD_IDLE,
                                          en_per, en_mid, en_lower, en_upper, 1'b0};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

endmodule

// ---- design/csrd_top_end.sv ----
// Spare design file; holds no logic

// ---- bench/csrd_assertions.sv ----
// Port-level checker for the chip-select range decoder
`timescale 1ns/10ps
module csrd_assertions
    import csrd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        cyc_start,
    input wire logic        cyc_is_mem,
    input wire logic [19:0] cyc_addr,
    input wire logic        bus_ready,
    input wire logic        upper_region_select_n,
    input wire logic        lower_region_select_n,
    input wire logic [3:0]  mid_range_select_n,
    input wire logic [6:0]  peripheral_select_n,
    input wire logic        cycle_done
);
    // ------------------------------------------------------------
    // Shadow of the accepted cycle and of the alternate control bits
    // ------------------------------------------------------------
    logic        busy_q;
    logic        pin_q;
    logic        mem_q;
    logic [19:0] addr_q;
    wire         go = cyc_start && !busy_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_q <= 1'b0;
        else if (go) busy_q <= 1'b1;
        else if (cycle_done) busy_q <= 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) addr_q <= 20'h00000;
        else if (go) addr_q <= cyc_addr;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
            mem_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == OFF_ALT) begin
            pin_q <= pwdata[PIN_SEL_BIT];
            mem_q <= pwdata[CYC_SEL_BIT];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    release_sel_a: assert property (cycle_done |=>
        upper_region_select_n && lower_region_select_n && &mid_range_select_n
        && &peripheral_select_n[4:0]) else $error("selects held after cycle end");
    io_only_a: assert property (go && !cyc_is_mem |=>
        upper_region_select_n && lower_region_select_n && &mid_range_select_n)
        else $error("memory select active in io cycle");
    lower_range_a: assert property (!lower_region_select_n |-> addr_q[19:18] == 2'b00)
        else $error("lower select outside bottom quarter");
    upper_range_a: assert property (!upper_region_select_n |-> addr_q[19:18] == 2'b11)
        else $error("upper select outside top quarter");
    mid_single_a: assert property ($onehot0(~mid_range_select_n))
        else $error("two mid quarters active");
    per_single_a: assert property ($onehot0(~peripheral_select_n[4:0]))
        else $error("two peripheral windows active");
    pin_addr_a: assert property (go && !pin_q |=> peripheral_select_n[6:5] == addr_q[2:1])
        else $error("pins do not show latched address");
    cycle_type_a: assert property (go && (cyc_is_mem != mem_q) |=> &peripheral_select_n[4:0])
        else $error("peripheral select on wrong cycle type");
    ready_needed_a: assert property (cycle_done && upper_region_select_n &&
        lower_region_select_n && &mid_range_select_n && &peripheral_select_n
        |-> $past(bus_ready, 2) || $past(bus_ready, 3) || $past(bus_ready, 4))
        else $error("unselected cycle ended without ready");
    done_pulse_a: assert property (cycle_done |=> !cycle_done)
        else $error("cycle end longer than one cycle");
endmodule
bind csrd_top csrd_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .cyc_start, .cyc_is_mem, .cyc_addr, .bus_ready, .upper_region_select_n,
    .lower_region_select_n, .mid_range_select_n, .peripheral_select_n, .cycle_done);

// ---- bench/csrd_bus_model.sv ----
// Memory and peripheral side: answers bus ready a set number of cycles into each cycle
`timescale 1ns/10ps
module csrd_bus_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cyc_start,
    input  wire logic       cycle_done,
    input  wire logic [5:0] ready_dly,
    output logic            bus_ready
);
    logic       busy_q;
    logic [5:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            cnt_q  <= 6'h00;
        end else if (cyc_start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q  <= 6'h00;
        end else if (cycle_done) begin
            busy_q <= 1'b0;
        end else if (busy_q && cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
    // Outside a cycle the line rests at its not-ready level
    assign bus_ready = busy_q && cnt_q >= ready_dly;
endmodule

// ---- bench/csrd_top_bench.sv ----
// Self-checking bench for the chip-select range decoder
`timescale 1ns/10ps
module csrd_top_bench;
    import csrd_pkg::*;
    localparam int TD = 2;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok;
    logic        cyc_start, cyc_is_mem, bus_ready, cycle_done, up_n, lo_n, pin, cty;
    logic [7:0]  paddr, uf, lf;
    logic [31:0] pwdata, prdata, rd, d;
    logic [19:0] cyc_addr;
    logic [20:0] s;
    logic [3:0]  mid_n;
    logic [6:0]  per_n, mb, blk;
    logic [5:0]  dly;
    logic [9:0]  pb;
    int          n_errors, tests_run, cycles, lat;
    logic [7:0]  offs [5] = '{OFF_UPPER, OFF_LOWER, OFF_ALT, OFF_MIDBASE, OFF_PERBASE};
    logic [15:0] rsts [5] = '{UPPER_RST, LOWER_RST, ALT_RST, MIDBASE_RST, PERBASE_RST};
    logic [15:0] msks [5] = '{REGION_MASK, REGION_MASK, ALT_MASK, MIDB_MASK, PERB_MASK};
    logic [20:0] ctab [17] = '{21'h100000, 21'h101fff, 21'h102000, 21'h1dffff, 21'h1e0000,
        21'h1fffff, 21'h120000, 21'h1207ff, 21'h120800, 21'h121fff, 21'h122000, 21'h001000,
        21'h00137f, 21'h001380, 21'h000fff, 21'h101000, 21'h0e0000};
    csrd_top #(.TSTATE_DIV(TD)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cyc_start, .cyc_is_mem, .cyc_addr, .bus_ready,
        .upper_region_select_n(up_n), .lower_region_select_n(lo_n),
        .mid_range_select_n(mid_n), .peripheral_select_n(per_n), .cycle_done);
    csrd_bus_model bm (.pclk, .presetn, .cyc_start, .cycle_done, .ready_dly(dly), .bus_ready);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Checking, bus tasks and expected decode
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rd = prdata;
            err = pslverr;
            ok = pready;
        end while (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [2:0] ut, lt, mt, pt, at);
        apb(1'b1, OFF_ALT, {17'h0, blk, pin, cty, 3'h0, at});
        apb(1'b1, OFF_MIDBASE, {16'h0, mb, 6'h0, mt});
        apb(1'b1, OFF_PERBASE, {16'h0, pb, 3'h0, pt});
        apb(1'b1, OFF_UPPER, {18'h0, uf, 3'h0, ut});
        apb(1'b1, OFF_LOWER, {18'h0, lf, 3'h0, lt});
    endtask
    function automatic logic [12:0] exp_sel(input logic [19:0] a, input logic m);
        logic [3:0] md;
        logic [6:0] p;
        int         sz, off;
        md = 4'hf;
        p = 7'h7f;
        sz = 0;
        for (int i = 0; i < 7; i++) if (blk[i]) sz = 8192 << i;
        off = int'(a) - int'(mb) * 8192;
        if (m && sz > 0 && off >= 0 && off < sz) md[off / (sz / 4)] = 1'b0;
        off = int'(a) - int'(pb) * 1024;
        if (m == cty && off >= 0 && off < 896) p[off / 128] = 1'b0;
        if (!pin) p[6:5] = a[2:1];
        return {!(m && a[19:18] == 2'b11 && a[17:10] >= uf),
                !(m && a[19:18] == 2'b00 && a[17:10] <= lf), md, p};
    endfunction
    task automatic bcyc(input logic [19:0] a, input logic m);
        @(posedge pclk);
        cyc_start <= 1'b1;
        cyc_addr <= a;
        cyc_is_mem <= m;
        @(posedge pclk);
        cyc_start <= 1'b0;
        @(negedge pclk);
        chk("selects", {19'h0, exp_sel(a, m)}, {19'h0, up_n, lo_n, mid_n, per_n});
        lat = 1;
        while (cycle_done !== 1'b1) begin
            @(negedge pclk);
            lat++;
        end
    endtask
    task automatic tcase(input logic [2:0] pt, at, input logic [19:0] a, input logic [5:0] dl,
                         input int lo, hi);
        dly = dl;
        cfg(3'h4, 3'h4, 3'h4, pt, at);
        bcyc(a, 1'b0);
        chk("latency", 1, lat >= lo && lat <= hi);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, cyc_start, cyc_is_mem, presetn} = '0;
        {paddr, pwdata, cyc_addr, n_errors, tests_run} = '0;
        dly = 6'h03;
        void'($urandom(32'h449f5dd8));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_STATUS, 0);
        chk("status after reset", 0, rd);
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 0);
            chk("reset value", {16'h0, rsts[i]}, rd);
        end
        apb(1'b0, 8'h18, 0);
        chk("unmapped error", 1, err);
        apb(1'b0, OFF_STATUS, 0);
        chk("enables after reads", 32'h1e, rd & 32'h1e);
        $display("reset and enable test finished");
        foreach (offs[i]) begin
            d = $urandom() & {16'h0, msks[i]};
            apb(1'b1, offs[i], d);
            apb(1'b0, offs[i], 0);
            chk("readback", d & {16'h0, msks[i]}, rd);
        end
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b0, OFF_STATUS, 0);
        chk("enables stay", 32'h1e, rd & 32'h1e);
        $display("register test finished");
        {uf, lf, blk, mb, pb, pin, cty} = {8'h80, 8'h07, 7'h01, 7'h10, 10'h004, 2'b10};
        cfg(3'h4, 3'h4, 3'h4, 3'h4, 3'h4);
        foreach (ctab[i]) bcyc(ctab[i][19:0], ctab[i][20]);
        repeat (40) begin
            d = $urandom();
            bcyc(d[19:0], d[20]);
        end
        for (int j = 0; j < 9; j++) begin
            uf = ~(8'hff >> (8 - j));
            lf = 8'hff >> (8 - j);
            cfg(3'h4, 3'h4, 3'h4, 3'h4, 3'h4);
            s = 21'h100000 - (21'h000400 << j);
            bcyc(s[19:0], 1'b1);
            bcyc(s[19:0] - 20'h1, 1'b1);
            s = (21'h000400 << j) - 21'h1;
            bcyc(s[19:0], 1'b1);
            bcyc(s[19:0] + 20'h1, 1'b1);
        end
        $display("decode test finished");
        {pin, cty} = 2'b01;
        cfg(3'h4, 3'h4, 3'h4, 3'h4, 3'h4);
        bcyc(20'h01302, 1'b1);
        bcyc(20'h01004, 1'b0);
        {pin, cty} = 2'b10;
        tcase(3'h0, 3'h4, 20'h01000, 6'd20, 20, 60);
        tcase(3'h0, 3'h4, 20'h01200, 6'd20, 1, 19);
        tcase(3'h0, 3'h7, 20'h01200, 6'd20, 3 * TD, 19);
        tcase(3'h0, 3'h3, 20'h01200, 6'd2, 3 * TD, 19);
        tcase(3'h0, 3'h3, 20'h01200, 6'd20, 20, 60);
        $display("wait and ready test finished");
        summarize();
    end
endmodule
